// *** hw/pdp_pkg.sv ***
// Shared constants and carrier types for the pin direction port block.
// Assumes a byte-wide register port on the core clock and eight pins per port.
`default_nettype none
package pdp_pkg;

    // Geometry
    localparam int NUM_PORTS = 7;
    localparam int PORT_W    = 8;
    localparam int ADDR_W    = 6;

    // Register map: port latch at an even offset, its direction register right after
    localparam logic [ADDR_W-1:0] PORT_DATA_BASE = 6'h00;
    localparam logic [ADDR_W-1:0] PORT_DIR_OFS   = 6'h01;
    localparam logic [ADDR_W-1:0] PORT_STRIDE    = 6'h02;
    localparam logic [ADDR_W-1:0] PORT_LAST_ADDR = 6'h0d;

    // Reset values: latch cleared, every pin an input
    localparam logic [PORT_W-1:0] LATCH_RST = 8'h00;
    localparam logic [PORT_W-1:0] DIR_RST   = 8'h00;
    localparam logic [PORT_W-1:0] RDATA_RST = 8'h00;

    // Ports that carry peripheral functions
    localparam int SERIAL3_PORT = 3;
    localparam int SERIAL1_PORT = 4;
    localparam int TIMER_PORT   = 5;

    // Bit positions of the function pins within their ports
    localparam int serial_receive_bit  = 4; // serial1_receive_pin / serial3_receive_pin
    localparam int serial_transmit_bit = 5; // serial1_transmit_pin / serial3_transmit_pin
    localparam int serial_clock_bit    = 6; // serial1_clock_pin / serial3_clock_pin
    localparam int serial_ready_bit    = 7; // serial1_ready_pin / serial3_ready_pin
    localparam int timer_x_counter_bit = 4; // timer_x_counter_pin
    localparam int timer_y_counter_bit = 5; // timer_y_counter_pin

    // Which pins of each port a peripheral may take over
    localparam logic [PORT_W-1:0] ALT_MASK [NUM_PORTS] = '{
        8'h00, 8'h00, 8'h00, 8'hf0, 8'hf0, 8'h30, 8'h00
    };

    // Request from an on-chip peripheral for the pins of one port
    typedef struct packed {
        logic [PORT_W-1:0] sel;  // Pin handed to the peripheral
        logic [PORT_W-1:0] oe;   // Peripheral drives the pin
        logic [PORT_W-1:0] dout; // Level the peripheral drives
    } pdp_alt_type;

    // Address decode: does the address hit port p, and which register
    function automatic logic pdp_hit(input logic [ADDR_W-1:0] addr, input int p,
                                     input logic dir_reg);
        logic [ADDR_W-1:0] base;
        base = PORT_DATA_BASE + ADDR_W'(p) * PORT_STRIDE;
        return addr == (dir_reg ? (base + PORT_DIR_OFS) : base);
    endfunction

endpackage

`default_nettype wire

// *** hw/pdp_port.sv ***
// Pin direction port: seven byte-wide ports with latch and direction register.
// Assumes the pad ring resolves pin level from drive and enable, and that
// peripheral requests come from logic on the same clock.
//
// Contract
// - One direction bit per pin, set independently
// - Direction zero makes pin input, driver off
// - Direction one drives pin from latch
// - Reading output pin returns latch value
// - Writing input pin only updates latch
// - Input pins stay undriven, high impedance
// - Port 4 bits 4-7 carry serial one
// - Port 3 bits 4-7 carry serial three
// - Port 5 bits 4-5 carry timer X/Y
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module pdp_port (
    // Clock and reset
    input  wire logic                      clock_in,
    input  wire logic                      rst_in,
    // Register port
    input  wire logic [pdp_pkg::ADDR_W-1:0] bus_addr_in,
    input  wire logic [pdp_pkg::PORT_W-1:0] bus_wdata_in,
    input  wire logic                      bus_wr_in,
    input  wire logic                      bus_rd_in,
    output logic      [pdp_pkg::PORT_W-1:0] bus_rdata_out,
    // Pads
    input  wire logic [pdp_pkg::PORT_W-1:0] pin_level_in   [pdp_pkg::NUM_PORTS],
    output logic      [pdp_pkg::PORT_W-1:0] pin_drive_out  [pdp_pkg::NUM_PORTS],
    output logic      [pdp_pkg::PORT_W-1:0] pin_enable_out [pdp_pkg::NUM_PORTS],
    // Peripheral functions
    input  wire pdp_pkg::pdp_alt_type       alt_in         [pdp_pkg::NUM_PORTS],
    output logic      [pdp_pkg::PORT_W-1:0] pin_sync_out   [pdp_pkg::NUM_PORTS]
);
    import pdp_pkg::*;

    logic [PORT_W-1:0] latch    [NUM_PORTS];
    logic [PORT_W-1:0] dir      [NUM_PORTS];
    logic [PORT_W-1:0] sync_a   [NUM_PORTS];
    logic [PORT_W-1:0] sync_b   [NUM_PORTS];
    logic [PORT_W-1:0] alt_sel  [NUM_PORTS];
    logic [PORT_W-1:0] port_val [NUM_PORTS];
    logic [PORT_W-1:0] next_rdata;

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            // Only pins wired to a peripheral may be taken over; others ignore requests
            assign alt_sel[p] = alt_in[p].sel & ALT_MASK[p];

            // Output latch: written whatever the direction, so a later switch
            // to output drives the value software prepared beforehand
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    latch[p] <= LATCH_RST;
                end else if (bus_wr_in && pdp_hit(bus_addr_in, p, 1'b0)) begin
                    latch[p] <= bus_wdata_in;
                end
            end

            // Direction register, one bit per pin
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    dir[p] <= DIR_RST;
                end else if (bus_wr_in && pdp_hit(bus_addr_in, p, 1'b1)) begin
                    dir[p] <= bus_wdata_in;
                end
            end

            // Two-stage synchroniser: pads are asynchronous to the core clock
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    sync_a[p] <= LATCH_RST;
                    sync_b[p] <= LATCH_RST;
                end else begin
                    sync_a[p] <= pin_level_in[p];
                    sync_b[p] <= sync_a[p];
                end
            end
            assign pin_sync_out[p] = sync_b[p];

            // Pad drive, registered so pads never see decode glitches
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    pin_enable_out[p] <= DIR_RST;
                    pin_drive_out[p]  <= LATCH_RST;
                end else begin
                    // Direction zero: enable low, pad floats; one: latch drives
                    pin_enable_out[p] <= (alt_sel[p] & alt_in[p].oe)
                                       | (~alt_sel[p] & dir[p]);
                    pin_drive_out[p]  <= (alt_sel[p] & alt_in[p].dout)
                                       | (~alt_sel[p] & latch[p]);
                end
            end

            // Read view: latch on output pins, pad level on input pins
            assign port_val[p] = (dir[p] & latch[p]) | (~dir[p] & sync_b[p]);
        end
    endgenerate

    // Read mux; unmapped addresses read as zero
    always_comb begin
        next_rdata = RDATA_RST;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (pdp_hit(bus_addr_in, i, 1'b0)) begin
                next_rdata = port_val[i];
            end
            if (pdp_hit(bus_addr_in, i, 1'b1)) begin
                next_rdata = dir[i];
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            bus_rdata_out <= RDATA_RST;
        end else if (bus_rd_in) begin
            bus_rdata_out <= next_rdata;
        end else begin
            bus_rdata_out <= RDATA_RST;
        end
    end

    // Checks; reset cycles are left out, since every register is forced then
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // Per-port checks, one copy for each port
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_chk
            // Writes aimed elsewhere leave this direction register alone
            chk_dir_holds: assert property (
                !(bus_wr_in && pdp_hit(bus_addr_in, p, 1'b1)) |=> dir[p] == $past(dir[p]))
                else $error("direction changed without its write");
            // The latch moves only on its own write
            chk_latch_holds: assert property (
                !(bus_wr_in && pdp_hit(bus_addr_in, p, 1'b0)) |=> latch[p] == $past(latch[p]))
                else $error("latch changed without its write");
            chk_dir_write_lands: assert property (
                bus_wr_in && pdp_hit(bus_addr_in, p, 1'b1) |=> dir[p] == $past(bus_wdata_in))
                else $error("direction write not stored");
            chk_input_floats: assert property (
                (dir[p] | alt_sel[p]) == 8'h00 |=> pin_enable_out[p] == 8'h00)
                else $error("input pin driven");
            chk_output_from_latch: assert property (
                1'b1 |=> ((pin_drive_out[p] ^ $past(latch[p])) & $past(dir[p] & ~alt_sel[p]))
                         == 8'h00 && (pin_enable_out[p] & $past(dir[p] & ~alt_sel[p]))
                         == $past(dir[p] & ~alt_sel[p]))
                else $error("output pin not driven from latch");
            chk_read_output_latch: assert property (
                bus_rd_in && pdp_hit(bus_addr_in, p, 1'b0)
                |=> (bus_rdata_out & $past(dir[p])) == $past(latch[p] & dir[p]))
                else $error("output pin read not latch");
            chk_write_latch_only: assert property (
                bus_wr_in && pdp_hit(bus_addr_in, p, 1'b0)
                |=> latch[p] == $past(bus_wdata_in) && dir[p] == $past(dir[p])
                    ##1 (pin_enable_out[p] & ~$past(dir[p], 2) & ~$past(alt_sel[p])) == 8'h00)
                else $error("latch write disturbed direction or drive");
            // A pin neither set to output nor taken over must float
            chk_float_holds: assert property (
                1'b1 |=> (pin_enable_out[p] & ~$past(dir[p] | alt_sel[p])) == 8'h00)
                else $error("floating pin driven");
            chk_read_input_pin: assert property (
                bus_rd_in && pdp_hit(bus_addr_in, p, 1'b0)
                |=> (bus_rdata_out & ~$past(dir[p])) == $past(sync_b[p] & ~dir[p]))
                else $error("input pin read not pad level");
            // Taken-over pins follow the peripheral, one edge later, on every wired bit
            chk_alt_routed: assert property (
                1'b1 |=> ((pin_enable_out[p] ^ $past(alt_in[p].oe)) & $past(alt_sel[p]))
                    == 8'h00
                    && ((pin_drive_out[p] ^ $past(alt_in[p].dout)) & $past(alt_sel[p]))
                    == 8'h00)
                else $error("peripheral pin not routed");
            // Second stage copies the first; nothing else reads the first stage
            chk_sync_stages: assert property (
                1'b1 |=> sync_b[p] == $past(sync_a[p]))
                else $error("pad synchroniser stage skipped");
        end
    endgenerate

    // Single-pin spot checks of each takeover group
    chk_serial1_takeover: assert property (
        alt_sel[SERIAL1_PORT][serial_transmit_bit] |=>
        pin_enable_out[SERIAL1_PORT][serial_transmit_bit]
            == $past(alt_in[SERIAL1_PORT].oe[serial_transmit_bit])
        && pin_drive_out[SERIAL1_PORT][serial_transmit_bit]
            == $past(alt_in[SERIAL1_PORT].dout[serial_transmit_bit]))
        else $error("serial one transmit not routed");
    chk_serial3_takeover: assert property (
        alt_sel[SERIAL3_PORT][serial_clock_bit] |=>
        pin_enable_out[SERIAL3_PORT][serial_clock_bit]
            == $past(alt_in[SERIAL3_PORT].oe[serial_clock_bit])
        && pin_drive_out[SERIAL3_PORT][serial_clock_bit]
            == $past(alt_in[SERIAL3_PORT].dout[serial_clock_bit]))
        else $error("serial three clock not routed");
    chk_timer_takeover: assert property (
        alt_sel[TIMER_PORT][timer_y_counter_bit] |=>
        pin_drive_out[TIMER_PORT][timer_y_counter_bit]
            == $past(alt_in[TIMER_PORT].dout[timer_y_counter_bit])
        && pin_enable_out[TIMER_PORT][timer_y_counter_bit]
            == $past(alt_in[TIMER_PORT].oe[timer_y_counter_bit]))
        else $error("timer counter pin not routed");
    // Requests on a port with no peripheral wiring must change nothing
    chk_masked_port_ignores: assert property (
        alt_in[0].sel != 8'h00 && dir[0] == 8'h00 |=> pin_enable_out[0] == 8'h00)
        else $error("peripheral request reached unwired port");

    // Read data must fall back to zero so a stale byte is never taken twice
    chk_rdata_one_cycle: assert property (
        !bus_rd_in |=> bus_rdata_out == RDATA_RST)
        else $error("read data held past its cycle");

    // Main scenarios
    cov_dir_then_read: cover property (
        bus_wr_in && pdp_hit(bus_addr_in, 2, 1'b1) ##1 bus_rd_in && pdp_hit(bus_addr_in, 2, 1'b0));
    cov_latch_before_dir: cover property (
        bus_wr_in && pdp_hit(bus_addr_in, 1, 1'b0) ##1 bus_wr_in && pdp_hit(bus_addr_in, 1, 1'b1));
    cov_serial1_active: cover property (alt_sel[SERIAL1_PORT] == 8'hf0);
    cov_serial3_active: cover property (alt_sel[SERIAL3_PORT] == 8'hf0);
    cov_timer_active: cover property (alt_sel[TIMER_PORT] == 8'h30);

endmodule // pdp_port

`default_nettype wire

// *** tb/pdp_pads.sv ***
// Pad model: board-side levels behind the seven byte-wide ports.
// Assumes device drive wins where its enable is high; the board drives every other pin.
`timescale 1ns/10ps
`default_nettype none

module pdp_pads (
    // Device side
    input  wire logic  [pdp_pkg::PORT_W-1:0] drive_in  [pdp_pkg::NUM_PORTS],
    input  wire logic  [pdp_pkg::PORT_W-1:0] enable_in [pdp_pkg::NUM_PORTS],
    // Board side
    input  wire logic  [pdp_pkg::PORT_W-1:0] board_in  [pdp_pkg::NUM_PORTS],
    output var logic   [pdp_pkg::PORT_W-1:0] level_out [pdp_pkg::NUM_PORTS]
);
    import pdp_pkg::*;

    // Resolve each pad; the board always drives, so a floating pin never reads X
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            level_out[p] = (enable_in[p] & drive_in[p]) | (~enable_in[p] & board_in[p]);
        end
    end
endmodule // pdp_pads

`default_nettype wire

// *** tb/pdp_port_test.sv ***
// Testbench for pdp_port: random register traffic, board levels and peripheral takeovers.
// Assumes the pad model in pdp_pads and fixed latencies of the register port.
`timescale 1ns/10ps
`default_nettype none

module pdp_port_test;
    import pdp_pkg::*;
    logic              clock_in, rst_in, bus_wr, bus_rd;
    logic [ADDR_W-1:0] bus_addr;
    logic [PORT_W-1:0] bus_wdata, bus_rdata, got, m, en, dr, lvl;
    logic [PORT_W-1:0] level [NUM_PORTS], drive [NUM_PORTS], enable [NUM_PORTS];
    logic [PORT_W-1:0] board [NUM_PORTS], sync [NUM_PORTS];
    pdp_alt_type       alt [NUM_PORTS];
    int                n_fail, tests_run, seed;
    int                latch_m [NUM_PORTS], dir_m [NUM_PORTS];

    pdp_port i_pdp_port (.clock_in(clock_in), .rst_in(rst_in), .bus_addr_in(bus_addr),
        .bus_wdata_in(bus_wdata), .bus_wr_in(bus_wr), .bus_rd_in(bus_rd),
        .bus_rdata_out(bus_rdata), .pin_level_in(level), .pin_drive_out(drive),
        .pin_enable_out(enable), .alt_in(alt), .pin_sync_out(sync));
    pdp_pads i_pdp_pads (.drive_in(drive), .enable_in(enable), .board_in(board),
        .level_out(level));

    // Clock at 25 ns
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // One-cycle write strobe; the model follows only mapped addresses
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock_in);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clock_in);
        bus_wr <= 1'b0;
        if (a <= PORT_LAST_ADDR && a[0]) dir_m[a >> 1] = d;
        else if (a <= PORT_LAST_ADDR) latch_m[a >> 1] = d;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clock_in);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clock_in);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask

    // Compare pads and both registers of one port with the model
    task automatic check_port(input int p);
        #1; // Let the edge's register updates settle before looking
        m = ALT_MASK[p] & alt[p].sel;
        en = (m & alt[p].oe) | (~m & 8'(dir_m[p]));
        dr = (m & alt[p].dout) | (~m & 8'(latch_m[p]));
        lvl = (en & dr) | (~en & board[p]);
        check(enable[p], en);
        check(drive[p] & en, dr & en);
        check(sync[p], lvl);
        rd(6'(2 * p), got);
        check(got, (8'(dir_m[p]) & 8'(latch_m[p])) | (~8'(dir_m[p]) & lvl));
        rd(6'(2 * p + 1), got);
        check(got, 8'(dir_m[p]));
    endtask

    initial begin
        seed = 32'hb5d6a406;
        {bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
        rst_in = 1'b1;
        for (int p = 0; p < NUM_PORTS; p++) begin
            board[p] = 8'h00;
            alt[p] = '0;
        end
        repeat (5) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        // Reset state: all inputs, latches clear
        for (int p = 0; p < NUM_PORTS; p++) check_port(p);
        // Random traffic, board levels and takeovers, unmapped addresses included
        for (int i = 0; i < 80; i++) begin
            @(posedge clock_in);
            for (int p = 0; p < NUM_PORTS; p++) begin
                board[p] <= 8'($random(seed));
                alt[p] <= (i % 3 == 0) ? pdp_alt_type'(24'($random(seed))) : '0;
            end
            wr(6'($random(seed) & 15), 8'($random(seed)));
            repeat (3) @(posedge clock_in);
            for (int p = 0; p < NUM_PORTS; p++) check_port(p);
            rd(6'(14 + {$random(seed)} % 50), got);
            check(got, RDATA_RST);
        end
        print_verdict();
    end
endmodule // pdp_port_test

`default_nettype wire
